// ### pkg/adcsr_pkg.sv
// package: constants for the serial readout converter block
package adcsr_pkg;
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          T_CONV_MIN_NS  = 500;
  localparam int          T_CONV_MAX_NS  = 2200;
  localparam int          CONV_MIN_CYC   = (T_CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CONV_MAX_CYC   = T_CONV_MAX_NS / CLK_PERIOD_NS;
  localparam int          RES_W          = 16;
  localparam int          SH_W           = RES_W + 1;
  localparam int          CNT_W          = 16;
  localparam logic [4:0]  FALLS_NO_BUSY  = 5'h10;
  localparam logic [4:0]  FALLS_BUSY     = 5'h11;
  localparam logic [7:0]  OFF_SAMPLE     = 8'h00;
  localparam logic [7:0]  OFF_CONV_TIME  = 8'h04;
  localparam logic [7:0]  OFF_STATUS     = 8'h08;
  localparam logic [7:0]  OFF_RESULT     = 8'h0c;
  localparam logic [15:0] SAMPLE_RESET   = 16'h8000;
  localparam logic [15:0] EXTRA_RESET    = 16'h0000;
  typedef enum logic [1:0] {ST_ACQ, ST_CONV, ST_READ} adcsr_state_t;
endpackage

// ### pkg/adcsr_shift_if.sv
// interface: control and data between core and output shifter
interface adcsr_shift_if;
  import adcsr_pkg::*;
  logic            load;
  logic [SH_W-1:0] load_word;
  logic            shift;
  logic            shift_in;
  logic            msb;
  modport ctrl (output load, output load_word, output shift, output shift_in, input msb);
  modport shreg (input load, input load_word, input shift, input shift_in, output msb);
endinterface

// ### rtl/adcsr_core.sv
// converter control: mode select, conversion timing, serial readout, apb registers
// Summary of operation
// RQ1 - data-in level at start rise picks mode
// RQ2 - tied data-in and start gives chain
// RQ3 - optional start bit ahead of result
// RQ4 - without busy host waits max conversion time
// RQ5 - select mode: busy if start/data-in low
// RQ6 - chain mode: busy if sclk high at rise
// RQ7 - 3-wire uses start, 4-wire adds select
// RQ8 - start rise begins conversion, output high-z
// RQ9 - conversion runs to end regardless of start
// RQ10 - host raises start early to suppress busy
// RQ11 - host holds start low to get busy
// RQ12 - after conversion return to acquisition, power down
// RQ13 - no busy: msb on start fall, shift
// RQ14 - data held across both sclk edges
// RQ15 - no busy: high-z after 16 falls
// RQ16 - busy: high-z until conversion completes
// RQ17 - busy: drive low at conversion end
// RQ18 - busy: result msb first on falls
// RQ19 - busy: high-z after 17 falls
// RQ20 - internal conversion clock, sclk not needed
// RQ21 - conversion end within min/max window
//
// Implementation choices: register access over APB and the register offsets.
module adcsr_core
  import adcsr_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              i_clk,
  input  wire logic              i_reset,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic      [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  input  wire logic              i_convert_start,
  input  wire logic              i_serial_data_in,
  input  wire logic              i_sclk,
  output logic                   o_serial_data_out,
  output logic                   o_serial_data_out_oe,
  output logic                   o_converting,
  output logic                   o_powered_down
);
  adcsr_shift_if sh ();

  logic [2:0]       pins_s;
  logic             cst_s;
  logic             din_s;
  logic             sclk_s;
  logic             cst_p;
  logic             din_p;
  logic             sclk_p;
  adcsr_state_t     state_q;
  adcsr_state_t     state_d;
  logic             cs_mode_q;
  logic             busy_q;
  logic             oe_q;
  logic             oe_d;
  logic [CNT_W-1:0] conv_cnt_q;
  logic [4:0]       falls_q;
  logic [15:0]      sample_q;
  logic [15:0]      extra_q;
  logic [15:0]      result_q;
  logic [31:0]      prdata_q;
  logic             pready_q;
  logic             pslverr_q;
  logic             converting_q;
  logic             pdown_q;

  adcsr_sync #(
    .W (3)
  ) u_sync (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_async ({i_convert_start, i_serial_data_in, i_sclk}),
    .o_sync  (pins_s)
  );

  adcsr_shifter u_shifter (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .sh      (sh)
  );

  assign cst_s  = pins_s[2];
  assign din_s  = pins_s[1];
  assign sclk_s = pins_s[0];

  // edge detection on the synchronised pin levels
  wire cst_rise  = cst_s & ~cst_p;
  wire sclk_fall = ~sclk_s & sclk_p;
  // read select is low start (3-wire) or low data-in (4-wire)
  wire sel_s     = ~(cst_s & din_s); // RQ7
  wire sel_p     = ~(cst_p & din_p);
  wire sel_on    = sel_s & ~sel_p;
  wire sel_off   = ~sel_s & sel_p;
  wire converting = (state_q == ST_CONV);

  // data-in taken a cycle before the edge, so a tied start reads low
  wire start_conv = cst_rise & ~converting; // RQ9
  wire new_mode   = din_p; // RQ1 RQ2
  wire new_busy   = ~din_p & sclk_p; // RQ6

  // conversion length from register, clamped into the legal window
  wire [CNT_W:0] end_raw = CNT_W'(CONV_MIN_CYC) + {1'b0, extra_q};
  wire [CNT_W-1:0] end_cyc = (end_raw > (CNT_W+1)'(CONV_MAX_CYC)) ?
                             CNT_W'(CONV_MAX_CYC) : end_raw[CNT_W-1:0]; // RQ21
  wire conv_done = converting & (conv_cnt_q == end_cyc - 1'b1); // RQ20

  wire       end_busy  = cs_mode_q ? sel_s : busy_q; // RQ5 RQ10 RQ11
  wire [4:0] fall_lim  = busy_q ? FALLS_BUSY : FALLS_NO_BUSY;
  wire       last_fall = cs_mode_q & (falls_q == fall_lim - 1'b1);
  wire       shifting  = (state_q == ST_READ) & sclk_fall & (oe_q | ~cs_mode_q);

  // start bit: low in select mode, high in chain mode
  wire [SH_W-1:0] cs_word    = end_busy ? {1'b0, sample_q} : {sample_q, 1'b0}; // RQ3
  wire [SH_W-1:0] chain_word = end_busy ? {1'b1, sample_q} : {sample_q, din_s};

  assign sh.load      = conv_done;
  assign sh.load_word = cs_mode_q ? cs_word : chain_word;
  assign sh.shift     = shifting; // RQ13 RQ14 RQ18
  assign sh.shift_in  = din_s;

  always_comb begin
    state_d = state_q;
    oe_d    = oe_q;
    case (state_q)
      ST_ACQ, ST_READ: begin
        if (start_conv) begin
          state_d = ST_CONV;
          oe_d    = 1'b0; // RQ8
        end else if (state_q == ST_READ) begin
          if (!cs_mode_q) begin
            oe_d = 1'b1;
          end else if (sel_off) begin
            oe_d = 1'b0; // RQ15 RQ19
          end else if (shifting && last_fall) begin
            oe_d = 1'b0; // RQ15 RQ19
          end else if (sel_on && !busy_q && falls_q == '0) begin
            oe_d = 1'b1; // RQ13
          end
        end
      end
      ST_CONV: begin
        oe_d = 1'b0; // RQ16
        if (conv_done) begin
          state_d = ST_READ; // RQ12
          oe_d    = cs_mode_q ? end_busy : 1'b1; // RQ17
        end
      end
      default: begin
        state_d = ST_ACQ;
        oe_d    = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cst_p   <= 1'b0;
      din_p   <= 1'b0;
      sclk_p  <= 1'b0;
      state_q <= ST_ACQ;
      oe_q    <= 1'b0;
    end else begin
      cst_p   <= cst_s;
      din_p   <= din_s;
      sclk_p  <= sclk_s;
      state_q <= state_d;
      oe_q    <= oe_d;
    end
  end

  // mode and chain busy choice are latched at the start edge, select busy at conversion end
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cs_mode_q <= 1'b1;
      busy_q    <= 1'b0;
    end else if (start_conv) begin
      cs_mode_q <= new_mode; // RQ1
      busy_q    <= new_busy; // RQ6
    end else if (conv_done) begin
      busy_q    <= end_busy; // RQ5
    end
  end

  // internal conversion timer, independent of sclk
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      conv_cnt_q <= '0;
    end else if (start_conv) begin
      conv_cnt_q <= '0;
    end else if (converting) begin
      conv_cnt_q <= conv_cnt_q + 1'b1; // RQ20
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      falls_q <= '0;
    end else if (start_conv || conv_done) begin
      falls_q <= '0;
    end else if (shifting && cs_mode_q) begin
      falls_q <= falls_q + 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      result_q     <= '0;
      converting_q <= 1'b0;
      pdown_q      <= 1'b1;
    end else begin
      if (conv_done) begin
        result_q <= sample_q;
      end
      converting_q <= (state_d == ST_CONV);
      pdown_q      <= (state_d != ST_CONV); // RQ12
    end
  end

  // apb slave: one wait state, write lands on the completing edge
  wire        apb_acc  = i_psel & i_penable;
  wire [7:0]  addr8    = 8'(i_paddr);
  wire        hit_smp  = (addr8 == OFF_SAMPLE);
  wire        hit_ext  = (addr8 == OFF_CONV_TIME);
  wire        hit_sts  = (addr8 == OFF_STATUS);
  wire        hit_res  = (addr8 == OFF_RESULT);
  wire        mapped   = hit_smp | hit_ext | hit_sts | hit_res;
  wire [31:0] status_w = {22'h0, falls_q, oe_q, busy_q, cs_mode_q, converting, 1'b0};
  wire [31:0] rd_mux   = hit_smp ? {16'h0, sample_q} :
                         hit_ext ? {16'h0, extra_q} :
                         hit_sts ? status_w :
                         hit_res ? {16'h0, result_q} : 32'h0;
  wire        wr_fire  = apb_acc & pready_q & i_pwrite & mapped;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= apb_acc & ~pready_q;
      pslverr_q <= apb_acc & ~pready_q & ~mapped;
      prdata_q  <= (apb_acc & ~pready_q & ~i_pwrite) ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      sample_q <= SAMPLE_RESET;
      extra_q  <= EXTRA_RESET;
    end else if (wr_fire) begin
      if (hit_smp) begin
        sample_q <= i_pwdata[15:0];
      end
      if (hit_ext) begin
        extra_q <= i_pwdata[15:0];
      end
    end
  end

  assign o_prdata             = prdata_q;
  assign o_pready             = pready_q;
  assign o_pslverr            = pslverr_q;
  assign o_serial_data_out    = sh.msb;
  assign o_serial_data_out_oe = oe_q;
  assign o_converting         = converting_q;
  assign o_powered_down       = pdown_q;

  // checks
  a_mode_latch: assert property (@(posedge i_clk) disable iff (i_reset)
    start_conv |=> cs_mode_q == $past(din_p)) else $error("mode not latched"); // RQ1
  a_tied_chain: assert property (@(posedge i_clk) disable iff (i_reset)
    start_conv && (cst_p == din_p) |=> !cs_mode_q) else $error("tied pins gave select"); // RQ2
  a_chain_busy: assert property (@(posedge i_clk) disable iff (i_reset)
    start_conv && !din_p |=> busy_q == $past(sclk_p)) else $error("chain busy wrong"); // RQ6
  a_conv_hiz: assert property (@(posedge i_clk) disable iff (i_reset)
    state_q == ST_CONV |-> !o_serial_data_out_oe) else $error("driven in conversion"); // RQ16
  a_conv_min: assert property (@(posedge i_clk) disable iff (i_reset)
    converting && conv_cnt_q < CNT_W'(CONV_MIN_CYC - 1) |=> state_q == ST_CONV)
    else $error("conversion ended early"); // RQ9
  a_conv_max: assert property (@(posedge i_clk) disable iff (i_reset)
    converting |-> conv_cnt_q < CNT_W'(CONV_MAX_CYC)) else $error("conversion too long"); // RQ21
  a_busy_start: assert property (@(posedge i_clk) disable iff (i_reset)
    conv_done && cs_mode_q && sel_s |=> ##1 oe_q && !o_serial_data_out)
    else $error("busy start bit missing"); // RQ17
  a_msb_first: assert property (@(posedge i_clk) disable iff (i_reset)
    state_q == ST_READ && cs_mode_q && !busy_q && sel_on && falls_q == '0 && !start_conv
    |=> oe_q && o_serial_data_out == result_q[15]) else $error("msb not driven"); // RQ13
  a_fall_release: assert property (@(posedge i_clk) disable iff (i_reset)
    shifting && last_fall && !start_conv |=> !oe_q) else $error("no release on last fall"); // RQ15
  a_desel_release: assert property (@(posedge i_clk) disable iff (i_reset)
    state_q == ST_READ && cs_mode_q && sel_off |=> !oe_q)
    else $error("no release on deselect"); // RQ19
  a_conv_start: assert property (@(posedge i_clk) disable iff (i_reset) // RQ8
    start_conv |=> state_q == ST_CONV && !oe_q)
    else $error("start edge did not begin conversion");
  a_start_ignored: assert property (@(posedge i_clk) disable iff (i_reset) // RQ9
    converting && cst_rise && !conv_done |=> state_q == ST_CONV)
    else $error("conversion cut by start edge");
  a_acq_return: assert property (@(posedge i_clk) disable iff (i_reset) // RQ12
    conv_done |=> state_q == ST_READ && o_powered_down)
    else $error("no return to acquisition");
  a_pdown_level: assert property (@(posedge i_clk) disable iff (i_reset) // RQ12
    converting |-> o_converting && !o_powered_down)
    else $error("power state wrong in conversion");
  a_select_busy: assert property (@(posedge i_clk) disable iff (i_reset) // RQ5
    conv_done && cs_mode_q |=> busy_q == $past(sel_s))
    else $error("select busy choice wrong");
  a_nobusy_hiz: assert property (@(posedge i_clk) disable iff (i_reset) // RQ13
    conv_done && cs_mode_q && !sel_s |=> !oe_q)
    else $error("driven before select");
  a_chain_drive: assert property (@(posedge i_clk) disable iff (i_reset) // RQ3
    conv_done && !cs_mode_q |=> oe_q && o_serial_data_out == ($past(busy_q) | $past(sample_q[15])))
    else $error("chain first bit wrong");
  a_chain_oe: assert property (@(posedge i_clk) disable iff (i_reset) // RQ3
    state_q == ST_READ && !cs_mode_q && !start_conv |=> oe_q)
    else $error("chain output released");
  a_fall_count: assert property (@(posedge i_clk) disable iff (i_reset) // RQ19
    state_q == ST_READ && cs_mode_q |-> falls_q <= FALLS_BUSY)
    else $error("too many falls counted");
  a_busy_limit: assert property (@(posedge i_clk) disable iff (i_reset) // RQ19
    state_q == ST_READ && cs_mode_q && busy_q && oe_q |-> falls_q < FALLS_BUSY)
    else $error("driven past last busy fall");
  a_mode_hold: assert property (@(posedge i_clk) disable iff (i_reset) // RQ1
    !start_conv |=> cs_mode_q == $past(cs_mode_q))
    else $error("mode changed without start");
  a_conv_floor: assert property (@(posedge i_clk) disable iff (i_reset) // RQ21
    conv_done |-> conv_cnt_q >= CNT_W'(CONV_MIN_CYC - 1))
    else $error("conversion shorter than minimum");
  a_result_take: assert property (@(posedge i_clk) disable iff (i_reset) // RQ21
    conv_done |=> result_q == $past(sample_q))
    else $error("result not captured");
  a_cnt_clear: assert property (@(posedge i_clk) disable iff (i_reset) // RQ20
    start_conv |=> conv_cnt_q == '0)
    else $error("timer not cleared");
  a_falls_clear: assert property (@(posedge i_clk) disable iff (i_reset) // RQ18
    conv_done |=> falls_q == '0)
    else $error("fall count not cleared");
endmodule

// ### rtl/adcsr_shifter.sv
// output shift register; msb drives the serial output
module adcsr_shifter
  import adcsr_pkg::*;
(
  input  wire logic  i_clk,
  input  wire logic  i_reset,
  adcsr_shift_if.shreg sh
);
  logic [SH_W-1:0] word_q;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      word_q <= '0;
    end else if (sh.load) begin
      word_q <= sh.load_word;
    end else if (sh.shift) begin
      word_q <= {word_q[SH_W-2:0], sh.shift_in};
    end
  end

  assign sh.msb = word_q[SH_W-1];
endmodule

// ### rtl/adcsr_sync.sv
// two-flop synchroniser for pin inputs
module adcsr_sync #(
  parameter int W = 3
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule

// ### tb/adcsr_core_tb_top.sv
// testbench: apb access plus host-driven conversions and readout
module adcsr_core_tb_top
  import adcsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] CODE = 16'ha5c3;
  logic        clk = 1'h0;
  logic        reset = 1'h1;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err;
  logic        cst, din, sclk, dout, dout_oe, converting, powered_down;
  logic [16:0] word;
  int          fail_count = 0;
  int          compares = 0;
  // pull-up on the serial line, so a released pin reads high
  wire         dout_line = dout_oe ? dout : 1'h1;
  always #5 clk = ~clk;
  adcsr_core i_dut (
    .i_clk               (clk),
    .i_reset             (reset),
    .i_psel              (psel),
    .i_penable           (penable),
    .i_pwrite            (pwrite),
    .i_paddr             (paddr),
    .i_pwdata            (pwdata),
    .o_prdata            (prdata),
    .o_pready            (pready),
    .o_pslverr           (pslverr),
    .i_convert_start     (cst),
    .i_serial_data_in    (din),
    .i_sclk              (sclk),
    .o_serial_data_out   (dout),
    .o_serial_data_out_oe(dout_oe),
    .o_converting        (converting),
    .o_powered_down      (powered_down)
  );
  adcsr_host_model i_host (
    .i_clk     (clk),
    .i_dout_line(dout_line),
    .o_cstart   (cst),
    .o_din      (din),
    .o_sclk    (sclk)
  );
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    if (fail_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // one transfer: setup, then access held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) fail_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  initial begin
    #200000;
    fail_count++;
    close_out();
  end
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    apb(1'h0, OFF_SAMPLE, 32'h0);
    check("sample reset", rd, {16'h0, SAMPLE_RESET});
    apb(1'h0, OFF_STATUS, 32'h0);
    check("status reset", rd, 32'h4);
    apb(1'h0, 8'h10, 32'h0);
    check("unmapped", {31'h0, err}, 32'h1);
    apb(1'h1, OFF_SAMPLE, {16'h0, CODE});
    // extra conversion cycles, then a value clamped to the maximum
    for (int k = 0; k < 2; k++) begin
      apb(1'h1, OFF_CONV_TIME, k ? 32'hffff : 32'h14);
      i_host.start(1'h1, 1'h0);
      repeat (k ? 212 : 62) @(posedge clk);
      check("converting", {31'h0, converting}, 32'h1);
      check("high-z", {31'h0, dout_oe}, 32'h0);
      repeat (20) @(posedge clk);
      check("conv end", {31'h0, converting}, 32'h0);
      check("powered down", {31'h0, powered_down}, 32'h1);
    end
    // brief low before the minimum: conversion goes on, no start bit
    i_host.start(1'h1, 1'h0);
    repeat (10) @(posedge clk);
    i_host.pins(1'h0, 1'h1, 1'h0);
    repeat (4) @(posedge clk);
    i_host.pins(1'h1, 1'h1, 1'h0);
    repeat (240) @(posedge clk);
    apb(1'h0, OFF_STATUS, 32'h0);
    check("status select", rd & 32'he, 32'h4);
    i_host.pins(1'h0, 1'h1, 1'h0);
    repeat (6) @(posedge clk);
    check("output driven", {31'h0, dout_oe}, 32'h1);
    i_host.read_bits(16, word);
    check("word", {15'h0, word}, {16'h0, CODE});
    check("released", {31'h0, dout_oe}, 32'h0);
    apb(1'h0, OFF_RESULT, 32'h0);
    check("result", rd, {16'h0, CODE});
    // a new start in mid-read releases the line at once
    i_host.start(1'h1, 1'h0);
    repeat (240) @(posedge clk);
    i_host.pins(1'h0, 1'h1, 1'h0);
    i_host.read_bits(4, word);
    i_host.pins(1'h1, 1'h1, 1'h0);
    repeat (6) @(posedge clk);
    check("abort", {31'h0, dout_oe}, 32'h0);
    repeat (240) @(posedge clk);
    // held low from before the minimum: start bit, then 17 falls
    i_host.start(1'h1, 1'h0);
    repeat (10) @(posedge clk);
    i_host.pins(1'h0, 1'h1, 1'h0);
    repeat (150) @(posedge clk);
    check("busy high-z", {31'h0, dout_oe}, 32'h0);
    repeat (90) @(posedge clk);
    check("start bit", {30'h0, dout_oe, dout}, 32'h2);
    i_host.read_bits(17, word);
    check("busy word", {15'h0, word}, {16'h0, CODE});
    check("busy released", {31'h0, dout_oe}, 32'h0);
    // chain mode; clock level at the start edge picks the start bit
    for (int k = 0; k < 2; k++) begin
      i_host.start(1'h0, k[0]);
      repeat (10) @(posedge clk);
      i_host.pins(1'h1, 1'h0, 1'h0);
      repeat (230) @(posedge clk);
      apb(1'h0, OFF_STATUS, 32'h0);
      check("status chain", rd & 32'he, {28'h0, k[0], 3'h0});
      i_host.read_bits(16 + k, word);
      check("chain word", {15'h0, word}, {15'h0, k[0], CODE});
    end
    i_host.pins(1'h0, 1'h0, 1'h0);
    repeat (4) @(posedge clk);
    i_host.pins(1'h1, 1'h1, 1'h0);
    repeat (240) @(posedge clk);
    apb(1'h0, OFF_STATUS, 32'h0);
    check("status tied", rd & 32'h4, 32'h0);
    close_out();
  end
endmodule

// ### tb/adcsr_host_model.sv
// host model: drives convert start, serial in and serial clock
module adcsr_host_model (
  input  wire logic i_clk,
  input  wire logic i_dout_line,
  output logic      o_cstart,
  output logic      o_din,
  output logic      o_sclk
);
  timeunit 1ns;
  timeprecision 100ps;
  initial o_cstart = 1'b0;
  initial o_din = 1'b1;
  initial o_sclk = 1'b0;
  // 3-wire: data-in only picks the mode, start and sclk do the rest
  task automatic pins(input logic cst, input logic din, input logic sck);
    o_cstart <= cst;
    o_din <= din;
    o_sclk <= sck;
    @(posedge i_clk);
  endtask
  // levels settle well ahead of the rising edge of convert start
  task automatic start(input logic din, input logic sck);
    pins(1'h0, din, sck);
    repeat (4) @(posedge i_clk);
    pins(1'h1, din, sck);
  endtask
  // 80 ns serial clock; sampled mid-high, stable on both edges
  task automatic read_bits(input int n, output logic [16:0] word);
    word = '0;
    for (int b = 0; b < n; b++) begin
      repeat (4) @(posedge i_clk);
      o_sclk <= 1'h1;
      repeat (2) @(posedge i_clk);
      word = {word[15:0], i_dout_line};
      repeat (2) @(posedge i_clk);
      o_sclk <= 1'h0;
    end
    repeat (8) @(posedge i_clk);
  endtask
endmodule
